// ===== ildec_core.sv
// immediate load and nop execution slice of the 4-bit core
// Operation
// - opcode 000111 loads nibble into accumulator
// - consecutive accumulator loads: only first executes
// - top bits 11 load x and y
// - consecutive xy loads: only first executes
// - opcode 00010010 loads two bits into z
// - all-zero word only advances program counter
`timescale 1ns/100ps
module ildec_core
  import ildec_pkg::*;
(
  input  wire logic                   CLK,
  input  wire logic                   RSTN,
  input  wire ildec_pkg::ildec_fetch_t FETCH,
  output logic [ildec_pkg::PC_W-1:0]  PC,
  output ildec_pkg::ildec_regs_t      REGS,
  output logic                        SKIPPED,
  output logic                        EXECUTED
);
  import ildec_pkg::*;

  logic              is_acc;     // accumulator load decoded
  logic              is_xy;      // xy load decoded
  logic              is_z;       // z load decoded
  logic              is_nop;     // no-operation decoded
  ildec_kind_t       prev_reg;   // kind of last fetched word
  ildec_kind_t       prev_next;  // its next value
  ildec_regs_t       regs_reg;   // register image
  ildec_regs_t       regs_next;  // its next value
  logic [PC_W-1:0]   pc_reg;     // program counter
  logic [PC_W-1:0]   pc_next;    // its next value
  logic              skip_reg;   // last word skipped
  logic              exec_reg;   // last word executed
  wire logic         fire;       // a word is fetched this cycle
  wire logic         skip_now;   // current word is a skipped repeat
  wire logic         do_acc;     // accumulator write strobe
  wire logic         do_xy;      // x and y write strobe
  wire logic         do_z;       // z write strobe
  // run detection
  wire logic         hit_acc;    // accumulator load repeats its run
  wire logic         hit_xy;     // xy load repeats its run
  // immediate fields split out of the fetched word
  logic [NIB_W-1:0]  acc_imm;    // accumulator immediate field
  logic [NIB_W-1:0]  x_imm;      // x immediate field
  logic [NIB_W-1:0]  y_imm;      // y immediate field
  logic [Z_W-1:0]    z_imm;      // z immediate field

  // opcode classifier
  ildec_classify u_classify
  (
    .word   (FETCH.word),
    .is_acc (is_acc),
    .is_xy  (is_xy),
    .is_z   (is_z),
    .is_nop (is_nop)
  );

  assign fire     = FETCH.valid;
  // immediate fields; an xy word carries x above y
  assign acc_imm  = FETCH.word[IMM_LSB +: NIB_W];
  assign x_imm    = FETCH.word[X_LSB +: NIB_W];
  assign y_imm    = FETCH.word[IMM_LSB +: NIB_W];
  assign z_imm    = FETCH.word[IMM_LSB +: Z_W];
  // a load repeats its run when the last fetched word was the same kind;
  // idle cycles leave the kind alone, so a gap does not end a run
  assign hit_acc  = is_acc && (prev_reg == ILDEC_K_ACC);
  assign hit_xy   = is_xy && (prev_reg == ILDEC_K_XY);
  // the run is tracked by kind, so a skipped word keeps the run alive
  assign skip_now = hit_acc || hit_xy;
  // write strobes: a skip blocks the write, z has no skip path
  assign do_acc   = fire && is_acc && !skip_now;
  assign do_xy    = fire && is_xy && !skip_now;
  assign do_z     = fire && is_z;
  // every fetched word, skipped or nop, steps the pc by one
  assign pc_next  = fire ? pc_reg + PC_STEP : pc_reg;

  // register write selection
  always_comb
  begin
    regs_next = regs_reg;
    // nop and skipped words leave the image untouched
    if (do_acc)
    begin
      // accumulator takes the low nibble
      regs_next.acc = acc_imm;
    end
    if (do_xy)
    begin
      // x comes from the upper nibble, y from the lower
      regs_next.x = x_imm;
      regs_next.y = y_imm;
    end
    if (do_z)
    begin
      // every z word writes, it never skips
      regs_next.z = z_imm;
    end
  end

  // run tracking: only fetched words update it
  always_comb
  begin
    prev_next = prev_reg;
    if (fire)
    begin
      // a load starts or continues its run
      if (is_acc)
      begin
        prev_next = ILDEC_K_ACC;
      end
      else if (is_xy)
      begin
        prev_next = ILDEC_K_XY;
      end
      else
      begin
        // any other word, nop included, ends the run
        prev_next = ILDEC_K_OTHER;
      end
    end
  end

  // state registers
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      // synchronous clear; a run never survives a reset
      pc_reg   <= PC_RST;
      regs_reg <= '{acc: NIB_RST, x: NIB_RST, y: NIB_RST, z: Z_RST};
      prev_reg <= ILDEC_K_OTHER;
      skip_reg <= 1'h0;
      exec_reg <= 1'h0;
    end
    else
    begin
      // every register steps on every edge, idle or not
      pc_reg   <= pc_next;
      regs_reg <= regs_next;
      prev_reg <= prev_next;
      // pulses last one cycle and tell a skip from an execute
      skip_reg <= fire && skip_now;
      exec_reg <= fire && !skip_now;
    end
  end

  assign PC       = pc_reg;
  assign REGS     = regs_reg;
  assign SKIPPED  = skip_reg;
  assign EXECUTED = exec_reg;

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  // an executed accumulator load lands its nibble
  acc_load_a: assert property
    (do_acc |=> REGS.acc == $past(acc_imm))
    else $error("accumulator not loaded");

  // a directly repeated accumulator load is skipped and writes nothing
  acc_run_skip_a: assert property
    (fire && is_acc ##1 fire && is_acc |=> SKIPPED && $stable(REGS.acc))
    else $error("repeated accumulator load not skipped");
  // idle cycles inside a run do not end it
  acc_gap_skip_a: assert property
    (fire && is_acc ##1 (!fire) [*2] ##1 fire && is_acc |=> SKIPPED && $stable(REGS.acc))
    else $error("accumulator load after gap not skipped");
  // the first accumulator load after another word always executes
  acc_first_a: assert property
    (fire && !is_acc ##1 fire && is_acc |=> EXECUTED && REGS.acc == $past(acc_imm))
    else $error("first accumulator load of a run skipped");

  // an executed xy load lands both nibbles
  xy_load_a: assert property
    (do_xy |=> REGS.x == $past(x_imm) && REGS.y == $past(y_imm))
    else $error("xy not loaded");
  // a directly repeated xy load is skipped and writes nothing
  xy_run_skip_a: assert property
    (fire && is_xy ##1 fire && is_xy |=> SKIPPED && $stable(REGS.x) && $stable(REGS.y))
    else $error("repeated xy load not skipped");
  // the first xy load after another word always executes
  xy_first_a: assert property
    (fire && !is_xy ##1 fire && is_xy |=> EXECUTED && REGS.x == $past(x_imm))
    else $error("first xy load of a run skipped");

  // z loads always land and never skip
  z_load_a: assert property
    (fire && is_z |=> REGS.z == $past(z_imm))
    else $error("z not loaded");
  z_no_skip_a: assert property
    (fire && is_z |=> EXECUTED && !SKIPPED)
    else $error("z load skipped");

  // nop moves only the program counter
  nop_only_pc_a: assert property
    (fire && is_nop |=> $stable(REGS) && PC == $past(PC) + PC_STEP && !SKIPPED)
    else $error("nop changed state");

  // a skipped word still costs its cycle and one pc step
  skip_pc_step_a: assert property
    (fire && skip_now |=> PC == $past(PC) + PC_STEP && !EXECUTED)
    else $error("skipped word did not step pc");
  skip_no_write_a: assert property
    (fire && skip_now |=> $stable(REGS))
    else $error("skipped word wrote a register");
  // without a fetch nothing moves and no pulse comes
  idle_hold_a: assert property
    (!fire |=> $stable(PC) && $stable(REGS) && !SKIPPED && !EXECUTED)
    else $error("state moved without fetch");

  // main scenarios reached by the bench
  acc_run_c: cover property (fire && is_acc ##1 fire && is_acc ##1 fire && is_acc);
  acc_gap_c: cover property (fire && is_acc ##1 (!fire) [*2] ##1 fire && is_acc);
  xy_run_c: cover property (fire && is_xy ##1 fire && is_xy);
  z_load_c: cover property (do_z);
  nop_c: cover property (fire && is_nop);
endmodule : ildec_core

// ===== ildec_pkg.sv
// shared constants and types for the immediate load and nop decoder
package ildec_pkg;
  localparam int unsigned INSTR_W = 10;   // instruction word width
  localparam int unsigned NIB_W   = 4;    // data nibble width
  localparam int unsigned Z_W     = 2;    // z register width
  localparam int unsigned PC_W    = 12;   // program counter width
  localparam logic [5:0] ACC_OPC  = 6'h07;  // upper six bits of acc load
  localparam logic [1:0] XY_OPC   = 2'h3;   // upper two bits of xy load
  localparam logic [7:0] Z_OPC    = 8'h12;  // upper eight bits of z load
  localparam logic [9:0] NOP_WORD = 10'h000; // all-zero no-operation word
  localparam logic [PC_W-1:0] PC_RST  = 12'h000; // program counter at reset
  localparam logic [PC_W-1:0] PC_STEP = 12'h001; // one word per instruction
  localparam logic [NIB_W-1:0] NIB_RST = 4'h0;   // register reset value
  localparam logic [Z_W-1:0]   Z_RST   = 2'h0;   // z reset value
  localparam int unsigned OPC_MSB     = 9;  // top bit of every opcode field
  localparam int unsigned ACC_OPC_LSB = 4;  // low bit of the acc load opcode
  localparam int unsigned XY_OPC_LSB  = 8;  // low bit of the xy load opcode
  localparam int unsigned Z_OPC_LSB   = 2;  // low bit of the z load opcode
  localparam int unsigned X_LSB       = 4;  // x nibble position in an xy word
  localparam int unsigned IMM_LSB     = 0;  // acc, y and z immediates start here

  // kind of the previous executed-or-skipped instruction
  typedef enum logic [1:0]
  {
    ILDEC_K_OTHER = 2'b00,
    ILDEC_K_ACC   = 2'b01,
    ILDEC_K_XY    = 2'b10
  } ildec_kind_t;

  // register file image carried out of the block
  typedef struct packed
  {
    logic [NIB_W-1:0] acc;
    logic [NIB_W-1:0] x;
    logic [NIB_W-1:0] y;
    logic [Z_W-1:0]   z;
  } ildec_regs_t;

  // instruction fetch beat
  typedef struct packed
  {
    logic               valid;
    logic [INSTR_W-1:0] word;
  } ildec_fetch_t;
endpackage : ildec_pkg

// ===== ildec_classify.sv
// instruction classifier: pure decode of one fetched word
`timescale 1ns/100ps
module ildec_classify
  import ildec_pkg::*;
(
  input  wire logic [ildec_pkg::INSTR_W-1:0] word,
  output wire logic                          is_acc,
  output wire logic                          is_xy,
  output wire logic                          is_z,
  output wire logic                          is_nop
);
  // field compares on the opcode bits
  assign is_acc = (word[OPC_MSB:ACC_OPC_LSB] == ACC_OPC);
  assign is_xy  = (word[OPC_MSB:XY_OPC_LSB] == XY_OPC);
  assign is_z   = (word[OPC_MSB:Z_OPC_LSB] == Z_OPC);
  assign is_nop = (word == NOP_WORD);
endmodule : ildec_classify

// ===== ildec_prog_mem.sv
// program memory model that feeds instruction words to the core
`timescale 1ns/100ps
module ildec_prog_mem
  import ildec_pkg::*;
(
  input  wire logic [ildec_pkg::PC_W-1:0] pc,
  input  wire logic                       en,
  output ildec_pkg::ildec_fetch_t         fetch
);
  logic [INSTR_W-1:0] mem [0:63]; // program image, filled by the bench
  // word follows the core pc, as a real fetch would
  assign fetch.valid = en;
  // idle cycles show the inverted word so stale data never looks valid
  assign fetch.word  = en ? mem[pc[5:0]] : ~mem[pc[5:0]];
endmodule : ildec_prog_mem

// ===== ildec_core_test.sv
// self-checking bench for the immediate load and nop core
`timescale 1ns/100ps
module ildec_core_test;
  import ildec_pkg::*;
  logic            clk    = 1'b0; // 20 MHz core clock
  logic            rst_n  = 1'b0; // held low at start
  logic            en     = 1'b0; // fetch enable into memory
  ildec_fetch_t    fetch;         // memory to core
  logic [PC_W-1:0] pc;            // core program counter
  ildec_regs_t     regs;          // core registers
  logic            skipped;       // skip pulse
  logic            executed;      // execute pulse
  ildec_regs_t     r      = '0;   // expected registers
  logic [PC_W-1:0] pc_exp = '0;   // expected pc
  int              errors = 0;
  int              checks_done = 0;
  // half period of 25 ns
  always #25 clk = ~clk;
  ildec_prog_mem i_ildec_prog_mem (.pc(pc), .en(en), .fetch(fetch));
  ildec_core i_ildec_core (.CLK(clk), .RSTN(rst_n), .FETCH(fetch), .PC(pc),
    .REGS(regs), .SKIPPED(skipped), .EXECUTED(executed));
  // compare and count, report at once
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one word taken at the next edge, then compare the result
  task automatic step(input logic [9:0] w, input logic es);
    i_ildec_prog_mem.mem[pc_exp[5:0]] = w;
    en = 1'b1;
    @(posedge clk);
    #1;
    pc_exp = pc_exp + PC_STEP;
    check({4'h0, pc}, {4'h0, pc_exp});
    check({2'h0, regs}, {2'h0, r});
    check({14'h0, executed, skipped}, {14'h0, !es, es});
  endtask : step
  // idle cycles must not move pc
  task automatic idle(input int n);
    en = 1'b0;
    repeat (n) @(posedge clk);
    #1;
    check({4'h0, pc}, {4'h0, pc_exp});
    check({2'h0, regs}, {2'h0, r});
    check({14'h0, executed, skipped}, 16'h0000);
  endtask : idle
  // acc run, gap inside run still skips
  task automatic acc_run;
    r.acc = 4'h5;
    step(10'h075, 1'b0);
    step(10'h07a, 1'b1);
    step(10'h07b, 1'b1);
    idle(2);
    step(10'h07c, 1'b1);
  endtask : acc_run
  // xy run right after acc run, then acc again
  task automatic xy_run;
    r.x = 4'ha;
    r.y = 4'h5;
    step(10'h3a5, 1'b0);
    step(10'h3c6, 1'b1);
    r.acc = 4'h0;
    step(10'h070, 1'b0);
  endtask : xy_run
  // every z value, back to back, never skipped
  task automatic z_all;
    for (int z = 3; z >= 0; z--)
    begin
      r.z = 2'(z);
      step(10'h048 + 10'(z), 1'b0);
    end
  endtask : z_all
  // nop leaves registers alone and ends no run wrongly
  task automatic nop_only;
    step(NOP_WORD, 1'b0);
    step(NOP_WORD, 1'b0);
    r.acc = 4'hf;
    step(10'h07f, 1'b0);
  endtask : nop_only
  // reset in mid-run clears state and ends the run
  task automatic reset_mid;
    rst_n = 1'h0;
    en    = 1'h0;
    @(posedge clk);
    #1;
    rst_n  = 1'h1;
    pc_exp = '0;
    r      = '0;
    check({4'h0, pc}, 16'h0000);
    check({2'h0, regs}, 16'h0000);
    check({14'h0, executed, skipped}, 16'h0000);
    r.acc = 4'h3;
    step(10'h073, 1'h0);
  endtask : reset_mid
  // counts, verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // reset for five cycles, then the scenarios
  initial
  begin
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    @(posedge clk);
    #1;
    check({4'h0, pc}, 16'h0000);
    check({2'h0, regs}, 16'h0000);
    check({14'h0, executed, skipped}, 16'h0000);
    acc_run();
    xy_run();
    z_all();
    nop_only();
    reset_mid();
    tally_and_finish();
  end
endmodule : ildec_core_test
